/* rtl/fswp_status_protect.sv */
// status register, write protection and serial framing of the flash
`default_nettype none
`include "fswp_defines.svh"

// Contract
// - busy high through program, erase, status write
// - while busy, only status read acts
// - busy clears when the operation ends
// - write latch flag set by write enable
// - write latch cleared by reset, disable, writes
// - region size bits written by status write
// - region size bits are zero after reset
// - lock and low protect pin freeze size bits
// - side select chooses top or bottom
// - side select frozen likewise, zero after reset
// - reserved status bit always reads zero
// - lock bit plus low pin rejects status writes
// - top ranges double from 64KB upward
// - bottom ranges double from 64KB upward
// - code zero protects none, seven protects all
// - program or erase into protection refused
// - frame starts at select fall, msb first
// - select rise ends frame, output released
// - writes need whole bytes or are dropped
// - opcode 06h sets write latch flag
// - status write updates bits 7,5,4,3,2 only
// - status read repeats status msb first
// - identification after three dummy bytes, repeating
module fswp_status_protect #(
    parameter logic [7:0]  DEVICE_ID  = 8'h5a,    // arbitrary value
    parameter int unsigned WSR_CYCLES = 5000,     // status write busy time
    parameter int unsigned PRG_CYCLES = 10000,    // page program busy time
    parameter int unsigned SEC_CYCLES = 20000,    // sector erase busy time
    parameter int unsigned BLK_CYCLES = 50000,    // block erase busy time
    parameter int unsigned ALL_CYCLES = 200000    // chip erase busy time
) (
    input  wire logic       mclk_i,               // system clock
    input  wire logic       rstn_i,               // async reset, active low
    input  wire logic       sclk_i,               // serial link clock
    input  wire logic       cs_n_i,               // chip select, active low
    input  wire logic       serial_in_out_i,      // serial data in
    input  wire logic       wp_n_i,               // protect pin, active low
    output logic            serial_out_o,         // serial data out
    output logic            serial_out_oe_o,      // serial out drive enable
    output logic [7:0]      status_o              // status byte, system clock
);
    import fswp_pkg::*;

    // ---------------- link clock domain ----------------
    fswp_frame_type frame_r;                      // frame record
    fswp_frame_type frame_nxt;                    // next frame record
    logic [6:0]     shift_r;                      // bits of byte in progress
    logic           first_r;                      // no edge yet in this frame
    logic [7:0]     stat_meta_r;                  // status, first sync stage
    logic [7:0]     stat_sync_r;                  // status, second sync stage
    logic           link_rst;                     // select high or reset
    logic [2:0]     bit_base;                     // bit count before this edge
    logic [3:0]     byte_base;                    // byte count before this edge
    logic [7:0]     byte_in;                      // byte completed by this edge
    logic [7:0]     out_byte;                     // byte being shifted out
    logic           rd_stat;                      // status read data phase
    logic           rd_id;                        // identification data phase

    assign link_rst = cs_n_i | ~rstn_i;

    // frame start marker, raised by select, cleared on the first rising edge
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            first_r <= 1'b1;
        end else begin
            first_r <= 1'b0;
        end
    end

    // next frame record: counts restart on the frame's first edge
    always_comb begin
        frame_nxt = frame_r;
        bit_base  = first_r ? 3'h0 : frame_r.bitpos;
        byte_base = first_r ? 4'h0 : frame_r.nbytes;
        byte_in   = {shift_r, serial_in_out_i};    // msb first
        frame_nxt.bitpos = bit_base + 3'h1;
        frame_nxt.nbytes = byte_base;
        if (bit_base == 3'h7) begin
            // byte complete, saturate the count
            if (byte_base != `FSWP_LEN_SAT) begin
                frame_nxt.nbytes = byte_base + 4'h1;
            end
            case (byte_base)
                4'h0: begin
                    frame_nxt.opcode = byte_in;
                end
                4'h1: begin
                    frame_nxt.data = byte_in;
                    frame_nxt.addr[23:16] = byte_in;
                end
                4'h2: begin
                    frame_nxt.addr[15:8] = byte_in;
                end
                4'h3: begin
                    frame_nxt.addr[7:0] = byte_in;
                end
                default: begin
                    frame_nxt.data = frame_r.data; // later bytes not kept
                end
            endcase
        end
    end

    // input sampling on rising link clock; record survives select high
    always_ff @(posedge sclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            frame_r <= '0;
            shift_r <= 7'h00;
        end else begin
            frame_r <= frame_nxt;
            shift_r <= byte_in[6:0];
        end
    end

    // status brought over bit by bit as independent levels
    always_ff @(posedge sclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stat_meta_r <= `FSWP_STATUS_RESET;
            stat_sync_r <= `FSWP_STATUS_RESET;
        end else begin
            stat_meta_r <= status_o;
            stat_sync_r <= stat_meta_r;
        end
    end

    // read phases; identification is dropped while busy
    assign rd_stat  = (frame_r.opcode == `FSWP_OP_RDSR) && (frame_r.nbytes != 4'h0);
    assign rd_id    = (frame_r.opcode == `FSWP_OP_DEV_ID)
                   && (frame_r.nbytes >= `FSWP_LEN_ID_DATA)
                   && !stat_sync_r[`FSWP_ST_BUSY];
    assign out_byte = rd_stat ? stat_sync_r : DEVICE_ID;

    // output shifting on falling link clock, released at once by select
    always_ff @(negedge sclk_i or posedge link_rst) begin
        if (link_rst) begin
            serial_out_o    <= 1'b0;
            serial_out_oe_o <= 1'b0;
        end else if (!first_r && (rd_stat || rd_id)) begin
            serial_out_o    <= out_byte[~frame_r.bitpos];
            serial_out_oe_o <= 1'b1;
        end else begin
            serial_out_o    <= 1'b0;
            serial_out_oe_o <= 1'b0;
        end
    end

    // ---------------- system clock domain ----------------
    fswp_state_type state_r;                      // operation engine
    logic [31:0]    timer_r;                      // busy cycles left
    logic           wel_r;                        // write latch flag
    logic [2:0]     region_size_r;                // region size bits
    logic           region_side_select_r;         // top or bottom
    logic           config_lock_bit_r;            // lock bit
    logic           cs_meta_r;                    // select, first sync stage
    logic           cs_sync_r;                    // select, second sync stage
    logic           cs_prev_r;                    // select, edge detect
    logic           wp_meta_r;                    // pin, first sync stage
    logic           wp_sync_r;                    // pin, second sync stage
    logic           frame_end;                    // select just rose
    logic           take;                         // frame acted on
    logic           whole;                        // frame ended on a byte edge
    logic           locked;                       // status write lockout
    logic [21:0]    span_lo;                      // first address touched
    logic [21:0]    span_hi;                      // last address touched
    logic [22:0]    region_len;                   // protected range length
    logic           hit;                          // span meets protection
    logic           go_wren;                      // write enable accepted
    logic           go_wrdi;                      // write disable accepted
    logic           go_wrsr;                      // status write accepted
    logic           go_prog;                      // program accepted
    logic           go_sec;                       // sector erase accepted
    logic           go_blk;                       // block erase accepted
    logic           go_all;                       // chip erase accepted
    logic           go_busy;                      // any busy operation starts

    // select and protect pin synchronisers
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cs_meta_r <= 1'b1;
            cs_sync_r <= 1'b1;
            cs_prev_r <= 1'b1;
            wp_meta_r <= 1'b1;
            wp_sync_r <= 1'b1;
        end else begin
            cs_meta_r <= cs_n_i;
            cs_sync_r <= cs_meta_r;
            cs_prev_r <= cs_sync_r;
            wp_meta_r <= wp_n_i;
            wp_sync_r <= wp_meta_r;
        end
    end

    // the record is stable once select is high, so it is read here then
    assign frame_end = cs_sync_r && !cs_prev_r;
    assign take      = frame_end && (state_r == FSWP_IDLE);
    assign whole     = (frame_r.bitpos == 3'h0) && (frame_r.nbytes != 4'h0);
    assign locked    = config_lock_bit_r && !wp_sync_r;

    // address span touched by the frame
    always_comb begin
        span_lo = frame_r.addr[21:0];
        span_hi = frame_r.addr[21:0];
        case (frame_r.opcode)
            `FSWP_OP_ERASE_SEC: begin
                span_lo = frame_r.addr[21:0] & ~`FSWP_SECTOR_MASK;
                span_hi = frame_r.addr[21:0] | `FSWP_SECTOR_MASK;
            end
            `FSWP_OP_ERASE_BLK: begin
                span_lo = frame_r.addr[21:0] & ~`FSWP_BLOCK_MASK;
                span_hi = frame_r.addr[21:0] | `FSWP_BLOCK_MASK;
            end
            `FSWP_OP_ERASE_ALL: begin
                span_lo = 22'h000000;
                span_hi = `FSWP_ARRAY_TOP;
            end
            default: begin
                span_lo = frame_r.addr[21:0];
            end
        endcase
    end

    // protected range decode and overlap test
    always_comb begin
        region_len = 23'(1) << (`FSWP_REGION_LOG2 + 5'(region_size_r));
        if (region_size_r == `FSWP_CODE_NONE) begin
            hit = 1'b0;
        end else if (region_size_r == `FSWP_CODE_ALL) begin
            hit = 1'b1;
        end else if (!region_side_select_r) begin
            hit = {1'b0, span_hi} >= (`FSWP_ARRAY_SIZE - region_len);
        end else begin
            hit = {1'b0, span_lo} < region_len;
        end
    end

    // acceptance of each instruction
    assign go_wren = take && whole && frame_r.opcode == `FSWP_OP_WREN
                  && frame_r.nbytes == `FSWP_LEN_ONE;
    assign go_wrdi = take && whole && frame_r.opcode == `FSWP_OP_WRDI
                  && frame_r.nbytes == `FSWP_LEN_ONE;
    assign go_wrsr = take && whole && wel_r && !locked && frame_r.opcode == `FSWP_OP_WRSR
                  && frame_r.nbytes == `FSWP_LEN_WRSR;
    assign go_prog = take && whole && wel_r && !hit && frame_r.opcode == `FSWP_OP_PROG
                  && frame_r.nbytes >= `FSWP_LEN_PROG;
    assign go_sec  = take && whole && wel_r && !hit && frame_r.opcode == `FSWP_OP_ERASE_SEC
                  && frame_r.nbytes == `FSWP_LEN_ERASE;
    assign go_blk  = take && whole && wel_r && !hit && frame_r.opcode == `FSWP_OP_ERASE_BLK
                  && frame_r.nbytes == `FSWP_LEN_ERASE;
    assign go_all  = take && whole && wel_r && !hit && frame_r.opcode == `FSWP_OP_ERASE_ALL
                  && frame_r.nbytes == `FSWP_LEN_ONE;
    assign go_busy = go_wrsr || go_prog || go_sec || go_blk || go_all;

    // operation engine with busy timer
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= FSWP_IDLE;
            timer_r <= 32'h0;
        end else begin
            case (state_r)
                FSWP_IDLE: begin
                    if (go_busy) begin
                        state_r <= FSWP_BUSY;
                        if (go_wrsr) begin
                            timer_r <= WSR_CYCLES - 1;
                        end else if (go_prog) begin
                            timer_r <= PRG_CYCLES - 1;
                        end else if (go_sec) begin
                            timer_r <= SEC_CYCLES - 1;
                        end else if (go_blk) begin
                            timer_r <= BLK_CYCLES - 1;
                        end else begin
                            timer_r <= ALL_CYCLES - 1;
                        end
                    end
                end
                FSWP_BUSY: begin
                    if (timer_r == 32'h0) begin
                        state_r <= FSWP_IDLE;
                    end else begin
                        timer_r <= timer_r - 32'h1;
                    end
                end
                default: begin
                    state_r <= FSWP_IDLE;
                end
            endcase
        end
    end

    // write latch flag
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wel_r <= 1'b0;
        end else if (go_wren) begin
            wel_r <= 1'b1;
        end else if (go_wrdi || go_busy) begin
            wel_r <= 1'b0;
        end
    end

    // protection bits, changed only by an accepted status write
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            region_size_r        <= `FSWP_CODE_NONE;
            region_side_select_r <= 1'b0;
            config_lock_bit_r    <= 1'b0;
        end else if (go_wrsr) begin
            region_size_r        <= frame_r.data[`FSWP_ST_BP_HI:`FSWP_ST_BP_LO];
            region_side_select_r <= frame_r.data[`FSWP_ST_TB];
            config_lock_bit_r    <= frame_r.data[`FSWP_ST_SRP];
        end
    end

    // registered status byte
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            status_o <= `FSWP_STATUS_RESET;
        end else begin
            status_o <= {config_lock_bit_r, 1'b0, region_side_select_r,
                         region_size_r, wel_r, state_r == FSWP_BUSY};
        end
    end

    // ---------------- checks ----------------
    property p_wren_sets;
        @(posedge mclk_i) disable iff (!rstn_i) go_wren |=> ##1 status_o[`FSWP_ST_WEL];
    endproperty
    a_wren_sets: assert property (p_wren_sets) else $error("write enable not seen");

    property p_wrdi_clears;
        @(posedge mclk_i) disable iff (!rstn_i) go_wrdi |=> !wel_r;
    endproperty
    a_wrdi_clears: assert property (p_wrdi_clears) else $error("write latch stuck");

    property p_busy_start;
        @(posedge mclk_i) disable iff (!rstn_i) go_busy |=> ##1 status_o[`FSWP_ST_BUSY] && !wel_r;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy not raised");

    property p_busy_hold;
        @(posedge mclk_i) disable iff (!rstn_i)
            state_r == FSWP_BUSY && timer_r != 32'h0 |=> state_r == FSWP_BUSY;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

    property p_busy_end;
        @(posedge mclk_i) disable iff (!rstn_i)
            state_r == FSWP_BUSY && timer_r == 32'h0 |=> ##1 !status_o[`FSWP_ST_BUSY];
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy not cleared");

    property p_busy_ignores;
        @(posedge mclk_i) disable iff (!rstn_i)
            frame_end && state_r == FSWP_BUSY |=> $stable(wel_r) && $stable(region_size_r);
    endproperty
    a_busy_ignores: assert property (p_busy_ignores) else $error("frame acted while busy");

    property p_lockout;
        @(posedge mclk_i) disable iff (!rstn_i)
            take && locked && frame_r.opcode == `FSWP_OP_WRSR
            |=> $stable({config_lock_bit_r, region_side_select_r, region_size_r});
    endproperty
    a_lockout: assert property (p_lockout) else $error("locked status written");

    property p_wrsr_bits;
        @(posedge mclk_i) disable iff (!rstn_i)
            go_wrsr |=> ##1 (status_o & 8'hbc) == ($past(frame_r.data, 2) & 8'hbc);
    endproperty
    a_wrsr_bits: assert property (p_wrsr_bits) else $error("status write bits wrong");

    property p_reserved;
        @(posedge mclk_i) disable iff (!rstn_i) !status_o[`FSWP_ST_RSVD];
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

    property p_protected_refused;
        @(posedge mclk_i) disable iff (!rstn_i)
            take && hit && (frame_r.opcode == `FSWP_OP_PROG
                         || frame_r.opcode == `FSWP_OP_ERASE_SEC
                         || frame_r.opcode == `FSWP_OP_ERASE_BLK
                         || frame_r.opcode == `FSWP_OP_ERASE_ALL)
            |=> state_r == FSWP_IDLE;
    endproperty
    a_protected_refused: assert property (p_protected_refused) else $error("protected write ran");

    property p_code_none;
        @(posedge mclk_i) disable iff (!rstn_i) region_size_r == `FSWP_CODE_NONE |-> !hit;
    endproperty
    a_code_none: assert property (p_code_none) else $error("code zero protects");

    c_wren: cover property (@(posedge mclk_i) disable iff (!rstn_i) go_wren);
    c_wrsr: cover property (@(posedge mclk_i) disable iff (!rstn_i) go_wrsr);
    c_refused: cover property (@(posedge mclk_i) disable iff (!rstn_i) take && hit && wel_r);
    c_busy_read: cover property (@(posedge mclk_i) disable iff (!rstn_i)
        frame_end && state_r == FSWP_BUSY && frame_r.opcode == `FSWP_OP_RDSR);

endmodule
`default_nettype wire

/* rtl/fswp_defines.svh */
// constants of the flash status and write protection block
`ifndef FSWP_DEFINES_SVH
`define FSWP_DEFINES_SVH

// instruction codes
`define FSWP_OP_WREN      8'h06
`define FSWP_OP_WRDI      8'h04
`define FSWP_OP_RDSR      8'h05
`define FSWP_OP_WRSR      8'h01
`define FSWP_OP_PROG      8'h02
`define FSWP_OP_ERASE_SEC 8'h20
`define FSWP_OP_ERASE_BLK 8'hd8
`define FSWP_OP_ERASE_ALL 8'hc7
`define FSWP_OP_DEV_ID    8'hab

// status byte positions
`define FSWP_ST_BUSY      0
`define FSWP_ST_WEL       1
`define FSWP_ST_BP_LO     2
`define FSWP_ST_BP_HI     4
`define FSWP_ST_TB        5
`define FSWP_ST_RSVD      6
`define FSWP_ST_SRP       7

// status byte reset value, factory state of the protection bits
`define FSWP_STATUS_RESET 8'h00

// byte counts that make a frame complete
`define FSWP_LEN_ONE      4'h1
`define FSWP_LEN_WRSR     4'h2
`define FSWP_LEN_ERASE    4'h4
`define FSWP_LEN_PROG     4'h5
`define FSWP_LEN_ID_DATA  4'h4
`define FSWP_LEN_SAT      4'hf

// array geometry
`define FSWP_ARRAY_TOP    22'h3fffff
`define FSWP_SECTOR_MASK  22'h000fff
`define FSWP_BLOCK_MASK   22'h00ffff
`define FSWP_REGION_LOG2  5'd15
`define FSWP_ARRAY_SIZE   23'h400000
`define FSWP_CODE_NONE    3'h0
`define FSWP_CODE_ALL     3'h7

`endif

/* rtl/fswp_pkg.sv */
// types of the flash status and write protection block
`default_nettype none
package fswp_pkg;

    // one serial frame as collected on the link clock
    typedef struct packed {
        logic [7:0]  opcode;  // first byte
        logic [7:0]  data;    // second byte
        logic [23:0] addr;    // bytes two to four
        logic [3:0]  nbytes;  // complete bytes, saturating
        logic [2:0]  bitpos;  // bits of the byte in progress
    } fswp_frame_type;

    // internal operation engine
    typedef enum logic {
        FSWP_IDLE = 1'b0,
        FSWP_BUSY = 1'b1
    } fswp_state_type;

endpackage
`default_nettype wire

/* verification/fswp_host_model.sv */
// serial bus master model that drives frames into the flash link
`default_nettype none
module fswp_host_model (
    output logic      sclk_o,   // link clock, stands low outside frames
    output logic      cs_n_o,   // chip select, active low
    output logic      mosi_o,   // data toward the device
    input  wire logic miso_i    // data from the device
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle bus after power-up
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end

    // one frame of n bits msb first at 80 ns per bit, last byte seen kept in rx
    task automatic xfer(input logic [47:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        #13 cs_n_o = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            #40 sclk_o = 1'b0;              // falling edge, device shifts out
            mosi_o = tx[i];
            #40 sclk_o = 1'b1;
            rx = {rx[6:0], miso_i};
        end
        #40 sclk_o = 1'b0;                  // clock rests low between frames
        #40 cs_n_o = 1'b1;
        mosi_o = ~mosi_o;                   // released line shows no stale value
        #200;
    endtask
endmodule
`default_nettype wire

/* verification/tb_fswp_status_protect.sv */
// self-checking bench of the flash status and write protection block
`default_nettype none
`include "fswp_defines.svh"
module tb_fswp_status_protect;
    timeunit 1ns;
    timeprecision 1ns;
    import fswp_pkg::*;

    logic       mclk_i;       // system clock
    logic       rstn_i;       // reset, active low
    logic       wp_n_i;       // protect pin, active low
    wire logic  sclk;         // link clock from the host
    wire logic  cs_n;         // select from the host
    wire logic  mosi;         // data into the device
    logic       so;           // data out of the device
    logic       so_oe;        // device drives data out
    wire logic  miso;         // data line as the host sees it
    logic [7:0] status;       // status byte
    logic [7:0] rx;           // last byte read back
    int         fails;        // mismatches
    int         comparisons;  // checks made

    fswp_status_protect #(.DEVICE_ID(8'h3c), .WSR_CYCLES(200), .PRG_CYCLES(200),
        .SEC_CYCLES(200), .BLK_CYCLES(200)) i_dut (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .sclk_i(sclk), .cs_n_i(cs_n),
        .serial_in_out_i(mosi), .wp_n_i(wp_n_i), .serial_out_o(so),
        .serial_out_oe_o(so_oe), .status_o(status));

    // a released data line reads high, as the device holds its output low when released
    assign miso = so_oe ? so : ~so;

    fswp_host_model i_host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));

    // 50 MHz system clock
    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end

    // compare one byte and count it
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // verdict and end of run
    task automatic end_sim;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // one frame, then settle on a falling system edge
    task automatic send(input logic [47:0] tx, input int n);
        i_host.xfer(tx, n, rx);
        @(negedge mclk_i);
    endtask

    // bounded wait for busy to drop
    task automatic idle;
        int k;
        for (k = 0; k < 1000 && status[0] !== 1'b0; k++) @(negedge mclk_i);
        if (k == 1000) begin
            fails++;
            $display("mismatch at %0t: busy stuck", $time);
            end_sim();
        end
    endtask

    // enabled status write followed by the wait for its end
    task automatic wr_status(input logic [7:0] d);
        send(`FSWP_OP_WREN, 8);
        send({`FSWP_OP_WRSR, d}, 16);
        idle();
    endtask

    // factory state and write latch set and clear
    task automatic t_basic;
        chk(status, 8'h00);
        send({`FSWP_OP_RDSR, 8'h00}, 16);
        chk(rx, 8'h00);
        send(`FSWP_OP_WREN, 8);
        chk(status, 8'h02);
        send(`FSWP_OP_WRDI, 8);
        chk(status, 8'h00);
        $display("test basic done");
    endtask

    // status write, busy read back, instruction dropped while busy
    task automatic t_wrsr;
        send(`FSWP_OP_WREN, 8);
        send({`FSWP_OP_WRSR, 8'hff}, 16);
        chk(status, 8'hbd);
        send({`FSWP_OP_RDSR, 8'h00}, 16);
        chk(rx, 8'hbd);
        send(`FSWP_OP_WREN, 8);
        idle();
        chk(status, 8'hbc);
        $display("test status write done");
    endtask

    // lock with pin low, partial frame, unlock with pin high
    task automatic t_lock;
        wp_n_i = 1'b0;
        send(`FSWP_OP_WREN, 8);
        send({`FSWP_OP_WRSR, 8'h00}, 16);
        chk(status, 8'hbe);
        wp_n_i = 1'b1;
        send(16'h0080, 15);
        chk(status, 8'hbe);
        send({`FSWP_OP_WRSR, 8'h00}, 16);
        chk(status, 8'h01);
        idle();
        $display("test lock done");
    endtask

    // identification after three dummy bytes, output released after select rise
    task automatic t_ident;
        send({`FSWP_OP_DEV_ID, 32'h0000_0000}, 40);
        chk(rx, 8'h3c);
        chk({7'h00, so_oe}, 8'h00);
        $display("test ident done");
    endtask

    // erase inside and outside the protected ranges
    task automatic t_protect;
        logic [7:0]  cfg [6] = '{8'h04, 8'h04, 8'h24, 8'h24, 8'h1c, 8'h20};
        logic [7:0]  op  [6] = '{8'h20, 8'h20, 8'hd8, 8'h20, 8'h20, 8'hd8};
        logic [23:0] adr [6] = '{24'h3f0000, 24'h3ef000, 24'h000000, 24'h010000,
                                 24'h200000, 24'h000000};
        logic        ok  [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 6; i++) begin
            wr_status(cfg[i]);
            send(`FSWP_OP_WREN, 8);
            send({op[i], adr[i]}, 32);
            chk(status, cfg[i] | (ok[i] ? 8'h01 : 8'h02));
            idle();
        end
        $display("test protect done");
    endtask

    // reset, then the scenarios in turn
    initial begin
        fails = 0;
        comparisons = 0;
        rstn_i = 1'b0;
        wp_n_i = 1'b1;
        repeat (3) @(negedge mclk_i);
        rstn_i = 1'b1;
        repeat (3) @(negedge mclk_i);
        t_basic();
        t_wrsr();
        t_lock();
        t_ident();
        t_protect();
        end_sim();
    end
endmodule
`default_nettype wire
